/* opt_cfg_map.vh */
// Field positions, codes, reset values and timing counts of the option byte decoder.
// Included by the decoder; definitions only.
`ifndef OPT_CFG_MAP_VH
`define OPT_CFG_MAP_VH

`define OPT_BYTE_ERASED 8'hFF
`define OPT_PKG_HIGH_BIT 7
`define OPT_RST_DELAY_BIT 6
`define OPT_SRC_HI 5
`define OPT_SRC_LO 4
`define OPT_BAND_HI 3
`define OPT_BAND_LO 1
`define OPT_PLL_OFF_BIT 0

`define SRC_RESONATOR 2'h0
`define SRC_EXT_RC 2'h1
`define SRC_INT_RC 2'h2
`define SRC_EXT_CLOCK 2'h3

`define BAND_LOWEST 3'h0
`define BAND_LOW_MID 3'h1
`define BAND_HIGH_MID 3'h2
`define BAND_HIGHEST 3'h3

`define PKG_QFP44 2'h0

`define RST_DELAY_LONG 13'h1000
`define RST_DELAY_SHORT 13'h0100

`define PORT_PADS 8

`endif

/* opt_cfg_properties.sv */
// Checker of the option byte decoder outputs.
// Bound to the decoder top; sees its ports only.
`timescale 1ns/1ps
module opt_cfg_checker (
  input wire clock,
  input wire rst_n,
  input wire package_select_low,
  input wire [1:0] clock_source_type,
  input wire [2:0] oscillator_freq_band,
  input wire resonator_drive_en,
  input wire pll_enable,
  input wire pll_config_bad,
  input wire [7:0] unbonded_pullup,
  input wire [1:0] package_code,
  input wire cpu_reset_active,
  input wire delay_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  drive_src_a: assert property (resonator_drive_en == (clock_source_type == 2'h0))
    else $error("drive bad");
  pll_bad_a: assert property (pll_config_bad == (pll_enable &&
    (clock_source_type == 2'h2 || oscillator_freq_band != 3'h1))) else $error("pll flag bad");
  pads_up_a: assert property (&unbonded_pullup)
    else $error("pad bad");
  hold_cfg_a: assert property (!cpu_reset_active |->
    $stable({clock_source_type, oscillator_freq_band, pll_enable, package_code}))
    else $error("config moved");
  done_pulse_a: assert property (delay_done |=> !delay_done)
    else $error("done long");
  done_end_a: assert property (delay_done |-> !cpu_reset_active && $past(cpu_reset_active))
    else $error("done early");
  pkg_low_a: assert property (!cpu_reset_active |-> package_code[0] == package_select_low)
    else $error("pkg bad");
  halt_wait_a: assert property ($rose(cpu_reset_active) |=> cpu_reset_active [*8])
    else $error("halt wait short");
endmodule

/* option_byte_clock_reset_config.v */
// Decodes the second option byte into clock, reset delay and package settings.
// Option byte comes from the programming-mode storage, or reads as erased (8'hFF) while option_valid is low; inputs synchronous to clock.
`timescale 1ns/1ps
`include "opt_cfg_map.vh"

module option_byte_clock_reset_config #(
  parameter PADS = `PORT_PADS
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] option_byte,
  input wire option_valid,
  input wire package_select_low,
  input wire clock_supervision,
  input wire main_osc_ready,
  input wire halt_exit,
  output reg [1:0] clock_source_type,
  output reg [2:0] oscillator_freq_band,
  output reg resonator_drive_en,
  output reg pll_enable,
  output reg pll_config_bad,
  output reg reset_delay_select,
  output reg [1:0] package_code,
  output reg [PADS-1:0] unbonded_pullup,
  output reg cpu_reset_active,
  output reg delay_done
);

////////////////////////////////////////////////////////////////////////////////
// Latched option byte

reg captured_r;
reg [7:0] opt_r;
reg pkg_low_r;
wire [7:0] opt_src;

assign opt_src = option_valid ? option_byte : `OPT_BYTE_ERASED;

localparam ST_CAPTURE = 3'b001;
localparam ST_COUNT = 3'b010;
localparam ST_RUN = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [12:0] count_r;
reg [12:0] count_nxt;
wire [12:0] delay_len;
wire count_tick;

assign delay_len = opt_r[`OPT_RST_DELAY_BIT] ? `RST_DELAY_SHORT : `RST_DELAY_LONG;
assign count_tick = clock_supervision | main_osc_ready;

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    captured_r <= 1'b0;
    opt_r <= `OPT_BYTE_ERASED;
    pkg_low_r <= 1'b1;
  end else if (!captured_r) begin
    captured_r <= 1'b1;
    opt_r <= opt_src;
    pkg_low_r <= package_select_low;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Reset and halt-exit delay sequencer

always @* begin
  state_nxt = state_r;
  count_nxt = count_r;
  case (state_r)
    ST_CAPTURE: begin
      if (captured_r) begin
        state_nxt = ST_COUNT;
        count_nxt = delay_len;
      end
    end
    ST_COUNT: begin
      if (count_tick) begin
        if (count_r == 13'h0001) begin
          state_nxt = ST_RUN;
        end
        count_nxt = count_r - 13'h0001;
      end
    end
    ST_RUN: begin
      if (halt_exit) begin
        state_nxt = ST_COUNT;
        count_nxt = delay_len;
      end
    end
    default: begin
      state_nxt = ST_CAPTURE;
      count_nxt = 13'h0000;
    end
  endcase
end

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    state_r <= ST_CAPTURE;
    count_r <= 13'h0000;
  end else begin
    state_r <= state_nxt;
    count_r <= count_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Option field decode

reg [1:0] source_nxt;
reg [2:0] band_nxt;
reg drive_nxt;
reg pll_on_nxt;
reg pll_bad_nxt;
reg delay_sel_nxt;
reg [1:0] package_nxt;
reg reset_active_nxt;
reg done_nxt;

always @* begin
  source_nxt = opt_r[`OPT_SRC_HI:`OPT_SRC_LO];
  band_nxt = opt_r[`OPT_BAND_HI:`OPT_BAND_LO];
  drive_nxt = 1'b0;
  case (source_nxt)
    `SRC_RESONATOR: begin
      drive_nxt = 1'b1;
    end
    `SRC_EXT_RC: begin
      drive_nxt = 1'b0;
    end
    `SRC_INT_RC: begin
      drive_nxt = 1'b0;
    end
    `SRC_EXT_CLOCK: begin
      drive_nxt = 1'b0;
    end
    default: begin
      drive_nxt = 1'b0;
    end
  endcase
  pll_on_nxt = ~opt_r[`OPT_PLL_OFF_BIT];
  pll_bad_nxt = 1'b0;
  if (pll_on_nxt) begin
    if (source_nxt == `SRC_INT_RC) begin
      pll_bad_nxt = 1'b1;
    end
    if (band_nxt != `BAND_LOW_MID) begin
      pll_bad_nxt = 1'b1;
    end
  end
  delay_sel_nxt = opt_r[`OPT_RST_DELAY_BIT];
  package_nxt = {opt_r[`OPT_PKG_HIGH_BIT], pkg_low_r};
  reset_active_nxt = (state_nxt != ST_RUN);
  done_nxt = (state_r == ST_COUNT) && (state_nxt == ST_RUN);
end

////////////////////////////////////////////////////////////////////////////////
// Clock configuration outputs, held stable after capture

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    clock_source_type <= `SRC_EXT_CLOCK;
    oscillator_freq_band <= 3'h7;
    resonator_drive_en <= 1'b0;
    pll_enable <= 1'b0;
    pll_config_bad <= 1'b0;
    reset_delay_select <= 1'b1;
  end else begin
    clock_source_type <= source_nxt;
    oscillator_freq_band <= band_nxt;
    resonator_drive_en <= drive_nxt;
    pll_enable <= pll_on_nxt;
    pll_config_bad <= pll_bad_nxt;
    reset_delay_select <= delay_sel_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Package code

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    package_code <= 2'h3;
  end else begin
    package_code <= package_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Unbonded pads held as pulled-up inputs

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    unbonded_pullup <= {PADS{1'b1}};
  end else begin
    unbonded_pullup <= {PADS{1'b1}};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Reset phase status outputs

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    cpu_reset_active <= 1'b1;
    delay_done <= 1'b0;
  end else begin
    cpu_reset_active <= reset_active_nxt;
    delay_done <= done_nxt;
  end
end

endmodule

/* option_byte_clock_reset_config_tb.sv */
// Self-checking bench of the option byte decoder.
// Needs the decoder and its checker.
`timescale 1ns/1ps
module option_byte_clock_reset_config_tb;
  reg clock, rst_n, valid, psl, sup, osc, hx;
  reg [7:0] ob;
  wire [1:0] src, pkg;
  wire [2:0] band;
  wire drv, pll, bad, dsel, busy, done;
  wire [7:0] pu;
  integer errors = 0, checks = 0, seed = 99, i, n;
  option_byte_clock_reset_config option_byte_clock_reset_config_inst (.clock(clock), .rst_n(rst_n),
    .option_byte(ob), .option_valid(valid), .package_select_low(psl), .clock_supervision(sup),
    .main_osc_ready(osc), .halt_exit(hx), .clock_source_type(src), .oscillator_freq_band(band),
    .resonator_drive_en(drv), .pll_enable(pll), .pll_config_bad(bad), .reset_delay_select(dsel),
    .package_code(pkg), .unbonded_pullup(pu), .cpu_reset_active(busy), .delay_done(done));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  function [15:0] decode(input [7:0] b, input p);
    decode = {5'h0, b[5:4], b[3:1], b[5:4] == 2'h0, ~b[0],
      ~b[0] & (b[5:4] == 2'h2 | b[3:1] != 3'h1), b[6], b[7], p};
  endfunction
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task run(input [7:0] b, input v);
    begin
      rst_n = 0; ob = b; valid = v; psl = $random(seed); sup = $random(seed); hx = 0;
      osc = ~sup;
      repeat (5) @(posedge clock);
      #1 rst_n = 1;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
        @(posedge clock);
        #1 n = n + 1;
        ob = $random(seed);
        hx = (n == 8);
      end
      if (!v) b = 8'hFF;
      check(n[15:0], b[6] ? 16'h0102 : 16'h1002);
      check({5'h0, src, band, drv, pll, bad, dsel, pkg}, decode(b, psl));
      check({8'h0, pu}, 16'h00FF);
      @(posedge clock);
      #1 hx = 1;
      @(posedge clock);
      #1 hx = 0;
      sup = 0;
      osc = 0;
      repeat (3) @(posedge clock);
      #1 check({15'h0, busy}, 16'h0001);
      osc = 1;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
        @(posedge clock);
        #1 n = n + 1;
      end
      check(n[15:0], b[6] ? 16'h0100 : 16'h1000);
    end
  endtask
  initial begin
    run(8'hFF, 0);
    run(8'h00, 1);
    run(8'h02, 1);
    run(8'h22, 1);
    run(8'hC3, 1);
    for (i = 0; i < 6; i = i + 1) run($random(seed), 1);
    print_verdict;
  end
  initial begin
    #450000;
    errors = errors + 1;
    print_verdict;
  end
endmodule
bind option_byte_clock_reset_config opt_cfg_checker opt_cfg_checker_inst (.clock(clock),
  .rst_n(rst_n), .package_select_low(package_select_low), .clock_source_type(clock_source_type),
  .oscillator_freq_band(oscillator_freq_band), .resonator_drive_en(resonator_drive_en),
  .pll_enable(pll_enable), .pll_config_bad(pll_config_bad), .unbonded_pullup(unbonded_pullup),
  .package_code(package_code), .cpu_reset_active(cpu_reset_active), .delay_done(delay_done));
